//--- sdw_consts.vh
`ifndef SDW_CONSTS_VH
`define SDW_CONSTS_VH

// ------------------------------------------------------------
// Frame geometry
// ------------------------------------------------------------
`define SDW_SHORT_CODE_W 14
`define SDW_LONG_CODE_W 16
`define SDW_SHORT_FRAME_BITS 16
`define SDW_LONG_FRAME_BITS 24
`define SDW_SHORT_EXEC_EDGE 5'h10
`define SDW_LONG_EXEC_EDGE 5'h12
`define SDW_CNT_W 5
`define SDW_CNT_ZERO 5'h00
`define SDW_CNT_ONE 5'h01

// ------------------------------------------------------------
// Power mode encodings
// ------------------------------------------------------------
`define SDW_MODE_NORMAL 2'h0
`define SDW_MODE_PD_1K 2'h1
`define SDW_MODE_PD_100K 2'h2
`define SDW_MODE_PD_HIZ 2'h3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SDW_CODE_RESET 16'h0000
`define SDW_SYNC_IDLE 3'h7
`define SDW_SCLK_IDLE 3'h0

// ------------------------------------------------------------
// Host timing
// ------------------------------------------------------------
`define SDW_SYNC_HIGH_MIN_NS 20
`define SDW_SCLK_MAX_MHZ 50

`endif

//--- sdw_serial_dac.v
`timescale 1ns/10ps
`include "sdw_consts.vh"
// Summary of operation
// - Loaded code is unsigned straight binary, full range for either width.
// - Power-up clears the code to zero until a valid complete write.
// - Mode bits: 00 normal, 01 1k to ground, 10 100k, 11 high impedance.
// - Any power-down mode disables the amplifier; modes 01 and 10 also select their termination.
// - Power-down leaves the stored code untouched.
// - Short variant uses a 16-bit shift register, mode bits first.
// - Frame select low starts a write; bits sampled on each clock falling edge.
// - Short variant executes on the 16th falling edge.
// - Short variant: early frame select rise discards the frame.
// - Long variant uses a 24-bit shift register, last six bits ignored.
// - Long variant executes on the 18th falling edge.
// - Long variant: early frame select rise discards the frame.
// - Long frame order: mode high, mode low, code 15..0, six filler bits.
module sdw_serial_dac #(
   parameter LONG_VARIANT = 0
)
(
   // Clock and reset
   input wire clock_i,
   input wire reset_i,
   input wire clk_en_i,
   // Serial link pins
   input wire frame_sel_n_i,
   input wire shift_clk_i,
   input wire serial_data_i,
   // Converter control
   output reg [15:0] dac_code_o,
   output reg [1:0] power_mode_o,
   output reg amp_enable_o,
   output reg term_1k_o,
   output reg term_100k_o,
   output reg update_o,
   output reg frame_abort_o
);

   // ------------------------------------------------------------
   // Variant constants
   // ------------------------------------------------------------
   localparam [4:0] EXEC_EDGE = LONG_VARIANT ? `SDW_LONG_EXEC_EDGE : `SDW_SHORT_EXEC_EDGE;
   localparam CODE_W = LONG_VARIANT ? `SDW_LONG_CODE_W : `SDW_SHORT_CODE_W;
   localparam SR_W = LONG_VARIANT ? `SDW_LONG_FRAME_BITS : `SDW_SHORT_FRAME_BITS;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // Three stages; a level counts only once stages two and three agree.
   reg [2:0] sync_sh_q;
   reg [2:0] sclk_sh_q;
   reg [2:0] sdi_sh_q;
   reg sync_n_q;
   reg sclk_q;
   reg sdi_q;

   always @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sync_sh_q <= `SDW_SYNC_IDLE;
         sclk_sh_q <= `SDW_SCLK_IDLE;
         sdi_sh_q <= `SDW_SCLK_IDLE;
         sync_n_q <= 1'b1;
         sclk_q <= 1'b0;
         sdi_q <= 1'b0;
      end
      else if (clk_en_i)
      begin
         sync_sh_q <= {sync_sh_q[1:0], frame_sel_n_i};
         sclk_sh_q <= {sclk_sh_q[1:0], shift_clk_i};
         sdi_sh_q <= {sdi_sh_q[1:0], serial_data_i};
         if (sync_sh_q[1] == sync_sh_q[2])
            sync_n_q <= sync_sh_q[2];
         if (sclk_sh_q[1] == sclk_sh_q[2])
            sclk_q <= sclk_sh_q[2];
         if (sdi_sh_q[1] == sdi_sh_q[2])
            sdi_q <= sdi_sh_q[2];
      end
   end

   // ------------------------------------------------------------
   // Edge detection
   // ------------------------------------------------------------
   // Data is taken from the filtered stage, which is one sample older than
   // the clock edge detection, giving the host's hold margin at 100 MHz.
   wire sclk_fall = sclk_q & ~(sclk_sh_q[1] & sclk_sh_q[2]) & (sclk_sh_q[1] == sclk_sh_q[2]);
   wire sync_rise = ~sync_n_q & sync_sh_q[1] & sync_sh_q[2];
   wire sync_fall = sync_n_q & ~sync_sh_q[1] & ~sync_sh_q[2];

   // ------------------------------------------------------------
   // Frame state machine
   // ------------------------------------------------------------
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_SHIFT = 2'h1;
   localparam [1:0] ST_DONE = 2'h2;

   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [SR_W-1:0] shift_q;
   reg [SR_W-1:0] shift_d;
   reg [4:0] cnt_q;
   reg [4:0] cnt_d;
   reg exec_d;
   reg abort_d;

   function [1:0] mode_of;
      input [SR_W-1:0] word;
      begin
         mode_of = word[SR_W-1:SR_W-2];
      end
   endfunction

   always @*
   begin
      state_d = state_q;
      shift_d = shift_q;
      cnt_d = cnt_q;
      exec_d = 1'b0;
      abort_d = 1'b0;
      case (state_q)
         ST_IDLE:
         begin
            if (sync_fall)
            begin
               state_d = ST_SHIFT;
               shift_d = {SR_W{1'b0}};
               cnt_d = `SDW_CNT_ZERO;
            end
         end
         ST_SHIFT:
         begin
            if (sync_rise)
            begin
               state_d = ST_IDLE;
               shift_d = {SR_W{1'b0}};
               cnt_d = `SDW_CNT_ZERO;
               abort_d = 1'b1;
            end
            else if (sclk_fall)
            begin
               // Bits enter at the LSB so the first bit ends at the top in the short variant and at bit 17 in the long one.
               shift_d = {shift_q[SR_W-2:0], sdi_q};
               cnt_d = cnt_q + `SDW_CNT_ONE;
               if (cnt_d == EXEC_EDGE)
               begin
                  exec_d = 1'b1;
                  state_d = ST_DONE;
               end
            end
         end
         ST_DONE:
         begin
            // Filler bits and extra edges are ignored; SYNC must rise.
            if (sync_rise)
            begin
               state_d = ST_IDLE;
               cnt_d = `SDW_CNT_ZERO;
            end
         end
         default:
         begin
            state_d = ST_IDLE;
            cnt_d = `SDW_CNT_ZERO;
         end
      endcase
   end

   // Executed word is aligned so the mode pair sits at the top.
   wire [SR_W-1:0] exec_word = LONG_VARIANT ?
      (shift_d << (SR_W - EXEC_EDGE)) : shift_d;

   // ------------------------------------------------------------
   // Code and mode registers
   // ------------------------------------------------------------
   always @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_q <= ST_IDLE;
         shift_q <= {SR_W{1'b0}};
         cnt_q <= `SDW_CNT_ZERO;
         dac_code_o <= `SDW_CODE_RESET;
         power_mode_o <= `SDW_MODE_NORMAL;
         amp_enable_o <= 1'b1;
         term_1k_o <= 1'b0;
         term_100k_o <= 1'b0;
         update_o <= 1'b0;
         frame_abort_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         state_q <= state_d;
         shift_q <= shift_d;
         cnt_q <= cnt_d;
         update_o <= exec_d;
         frame_abort_o <= abort_d;
         if (exec_d)
         begin
            // Code is straight binary, zero-extended for the short variant.
            // A power-down word leaves the stored code as it was; the normal-mode word
            // that wakes the part loads its own code in the same update.
            if (mode_of(exec_word) == `SDW_MODE_NORMAL)
               dac_code_o <= {{(16-CODE_W){1'b0}},
                  exec_word[SR_W-3 -: CODE_W]};
            power_mode_o <= mode_of(exec_word);
            amp_enable_o <= (mode_of(exec_word) == `SDW_MODE_NORMAL);
            term_1k_o <= (mode_of(exec_word) == `SDW_MODE_PD_1K);
            term_100k_o <= (mode_of(exec_word) == `SDW_MODE_PD_100K);
         end
      end
   end

endmodule

//--- sdw_serial_dac_properties.sv
`timescale 1ns/10ps
module sdw_serial_dac_properties #(
   parameter LONG_VARIANT = 0
)
(
   // Clock, reset and link pins
   input wire clock_i,
   input wire reset_i,
   input wire clk_en_i,
   input wire frame_sel_n_i,
   input wire shift_clk_i,
   input wire serial_data_i,
   // Converter control
   input wire [15:0] dac_code_o,
   input wire [1:0] power_mode_o,
   input wire amp_enable_o,
   input wire term_1k_o,
   input wire term_100k_o,
   input wire update_o,
   input wire frame_abort_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   sequence s_idle; frame_sel_n_i [*8]; endsequence
   property p_upd; update_o |=> !update_o; endproperty
   a_upd: assert property (p_upd) else $error("update too long");
   property p_abt; frame_abort_o |=> !frame_abort_o && !update_o; endproperty
   a_abt: assert property (p_abt) else $error("abort too long");
   property p_code; $changed(dac_code_o) |-> update_o; endproperty
   a_code: assert property (p_code) else $error("code moved");
   property p_mode; $changed(power_mode_o) |-> update_o; endproperty
   a_mode: assert property (p_mode) else $error("mode moved");
   property p_amp; amp_enable_o == (power_mode_o == 2'h0); endproperty
   a_amp: assert property (p_amp) else $error("amplifier wrong");
   property p_term; term_1k_o == (power_mode_o == 2'h1) && term_100k_o == (power_mode_o == 2'h2);
   endproperty
   a_term: assert property (p_term) else $error("termination wrong");
   property p_keep; update_o && power_mode_o != 2'h0 |-> $stable(dac_code_o); endproperty
   a_keep: assert property (p_keep) else $error("code lost");
   property p_idle; s_idle |-> !update_o && !frame_abort_o; endproperty
   a_idle: assert property (p_idle) else $error("pulse while idle");
endmodule

//--- sdw_host_model.sv
`timescale 1ns/10ps
module sdw_host_model
(
   // Serial link pins
   output reg frame_sel_n_o,
   output reg shift_clk_o,
   output reg serial_data_o
);
   initial
   begin
      frame_sel_n_o = 1'b1;
      shift_clk_o = 1'b0;
      serial_data_o = 1'b0;
   end
   // Data moves on the rising shift edge, so it is settled around each fall.
   task send(input [23:0] word, input integer nbits);
      integer i;
      begin
         frame_sel_n_o = 1'b0;
         #62.5;
         for (i = 0; i < nbits; i = i + 1)
         begin
            shift_clk_o = 1'b1;
            serial_data_o = word[23-i];
            #62.5;
            shift_clk_o = 1'b0;
            #62.5;
         end
         frame_sel_n_o = 1'b1;
         serial_data_o = ~serial_data_o;
         #100;
      end
   endtask
endmodule

//--- serial_dac_write_and_powerdown_tb.sv
`timescale 1ns/10ps
module serial_dac_write_and_powerdown_tb;
   reg clock_i = 1'b0;
   reg reset_i = 1'b1;
   reg clk_en_i = 1'b1;
   wire fs_n, sck, sdi, upd, abt, amp, t1k, t100k;
   wire [15:0] code;
   wire [1:0] mode;
   integer n_mismatch = 0, n_checks = 0, n_upd = 0, n_abt = 0, cyc = 0;
   integer e_code = 0, e_mode = 0, e_upd = 0, e_abt = 0, k;
   reg [15:0] lfsr_q = 16'h0005;
   always #5 clock_i = ~clock_i;
   sdw_host_model host_u(.frame_sel_n_o(fs_n), .shift_clk_o(sck), .serial_data_o(sdi));
   sdw_serial_dac dut_u(.clock_i(clock_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
      .frame_sel_n_i(fs_n), .shift_clk_i(sck), .serial_data_i(sdi), .dac_code_o(code),
      .power_mode_o(mode), .amp_enable_o(amp), .term_1k_o(t1k), .term_100k_o(t100k),
      .update_o(upd), .frame_abort_o(abt));
   function [15:0] lfsr_next(input [15:0] v);
      lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task close_out;
      begin
         $display("checks %0d mismatches %0d", n_checks, n_mismatch);
         if (n_mismatch == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task chk(input [63:0] name, input integer exp, input [31:0] got);
      begin
         n_checks = n_checks + 1;
         if (got !== exp)
         begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected %0s expected %0d seen %0d", name, exp, got);
         end
      end
   endtask
   task verify;
      begin
         chk("code", e_code, {16'h0000, code});
         chk("mode", e_mode, {30'h0, mode});
         chk("outs", e_mode == 0 ? 4 : e_mode == 1 ? 2 : e_mode == 2 ? 1 : 0,
            {29'h0, amp, t1k, t100k});
         chk("updates", e_upd, n_upd);
         chk("aborts", e_abt, n_abt);
      end
   endtask
   task frame(input [1:0] m, input [13:0] c, input integer n);
      begin
         #1;
         host_u.send({m, c, 8'h00}, n);
         e_upd = e_upd + (n >= 16);
         e_abt = e_abt + (n < 16);
         if (n >= 16)
         begin
            e_mode = m;
            e_code = (m == 2'h0) ? c : e_code;
         end
         repeat (2) @(posedge clock_i);
         verify;
      end
   endtask
   always @(posedge clock_i)
   begin
      cyc <= cyc + 1;
      n_upd <= n_upd + (upd === 1'b1);
      n_abt <= n_abt + (abt === 1'b1);
      if (cyc == 20000)
      begin
         n_mismatch = n_mismatch + 1;
         close_out;
      end
   end
   initial
   begin
      repeat (2) @(posedge clock_i);
      reset_i <= 1'b0;
      @(posedge clock_i);
      verify;
      frame(2'h0, 14'h3FFF, 16);
      for (k = 0; k < 4; k = k + 1)
      begin
         lfsr_q = lfsr_next(lfsr_q);
         frame(k[1:0], lfsr_q[13:0], 16);
      end
      lfsr_q = lfsr_next(lfsr_q);
      frame(2'h0, lfsr_q[13:0], 15);
      frame(2'h0, 14'h1234, 20);
      frame(2'h0, 14'h0000, 16);
      close_out;
   end
endmodule
bind sdw_serial_dac sdw_serial_dac_properties #(.LONG_VARIANT(LONG_VARIANT)) chk_u(
   .clock_i(clock_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .frame_sel_n_i(frame_sel_n_i),
   .shift_clk_i(shift_clk_i), .serial_data_i(serial_data_i), .dac_code_o(dac_code_o),
   .power_mode_o(power_mode_o), .amp_enable_o(amp_enable_o), .term_1k_o(term_1k_o),
   .term_100k_o(term_100k_o), .update_o(update_o), .frame_abort_o(frame_abort_o));
